/* logic/mcs_pkg.sv */
package mcs_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FFM_HOLD_MS = 10000;
  localparam logic [16:0] FFM_HOLD_TICKS = 17'(FFM_HOLD_MS);
  localparam logic [16:0] SYM_DELAY_MIN = 17'h01388;
  localparam logic [16:0] SYM_DELAY_MAX = 17'h186A0;

  // ************************************************************
  // Fixed thresholds (current LSB 1 mA, voltage LSB 10 mV)
  // ************************************************************
  localparam logic [15:0] NOISE_I = 16'h0028;
  localparam logic [15:0] BW_LOAD_MIN = 16'h00C8;
  localparam logic [15:0] ROT_MIN_U = 16'h0905;
  localparam logic [5:0] DROP_NUM = 6'h21;
  localparam logic [5:0] DROP_DEN = 6'h20;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] I_BAL_OFS = 8'h04;
  localparam logic [7:0] U_BAL_OFS = 8'h08;
  localparam logic [7:0] I_DLY_OFS = 8'h0C;
  localparam logic [7:0] U_DLY_OFS = 8'h10;
  localparam logic [7:0] FFM_ASYM_OFS = 8'h14;
  localparam logic [7:0] FFM_3PH_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  localparam logic [31:0] CTRL_RST = 32'h00000001;
  localparam logic [31:0] I_BAL_RST = 32'h00320080;
  localparam logic [31:0] U_BAL_RST = 32'h0BB80080;
  localparam logic [31:0] FFM_ASYM_RST = 32'h006407D0;
  localparam logic [31:0] FFM_3PH_RST = 32'h006407D0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [2:0][15:0] i_mag;
    logic [2:0][15:0] u_pe;
    logic [2:0][15:0] u_pp;
    logic [2:0][15:0] i_stored;
    logic stored_valid;
    logic rot_negative;
    logic [15:0] u0;
    logic [15:0] u2;
    logic [15:0] i0;
    logic [15:0] i2;
  } mcs_meas_t;

  typedef struct packed {
    logic comm_ok;
    logic remote_high_fault;
    logic remote_stable;
    logic [2:0] remote_break;
  } mcs_peer_t;

  typedef enum logic [4:0] {
    FFM_IDLE = 5'h01,
    FFM_BLOCK = 5'h02,
    FFM_LIFTED = 5'h04,
    FFM_LATCHED = 5'h08,
    FFM_RELEASE = 5'h10
  } mcs_ffm_t;

endpackage

/* logic/mcs_top.sv */
// Contract
// - Checks run only while no pickup
// - Current asymmetry: min/max below ratio, max above floor
// - Symmetry flags drop out near 97 percent
// - Current asymmetry alarm after 5 to 100 s
// - Voltage asymmetry likewise, alarm after set delay
// - Abrupt drop to zero marks suspected break
// - Local break: alarm, block differential, tell peers
// - Comm loss: emergency, local only, no multipole
// - Current return or remote high fault cancels blocking
// - Rotation check above 40 V over root three
// - Asym VT failure: U0/U2 high, I0/I2 low
// - Non-earthed systems use only negative-sequence voltage
// - Block undervoltage, alarm, needs some phase current
// - No immediate block during single-pole open
// - Sequence current within 10 s lifts; else latch
// - Latched block releases 10 s after clearing
// - Three-phase failure: low voltages, small current change
// - Without stored currents, all currents above 40 mA
// - Three-phase block clears as soon as the voltage or current condition fails
`timescale 1ns/1ns
module mcs_top #(
  parameter int TICK_LEN = mcs_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire mcs_pkg::mcs_meas_t meas,
  input wire logic meas_valid,
  input wire logic pickup,
  input wire logic single_pole_open,
  input wire mcs_pkg::mcs_peer_t peer,
  output logic current_asym_alarm,
  output logic voltage_asym_alarm,
  output logic [2:0] local_open_ct_phase_alarm,
  output logic [2:0] remote_open_ct_phase_alarm,
  output logic [2:0] break_tx,
  output logic diff_block,
  output logic phase_rotation_alarm,
  output logic vt_circuit_loss_alarm,
  output logic undervoltage_block
);
  import mcs_pkg::*;

  function automatic logic [15:0] min3(input logic [2:0][15:0] v);
    logic [15:0] m;
    m = (v[0] < v[1]) ? v[0] : v[1];
    min3 = (v[2] < m) ? v[2] : m;
  endfunction

  function automatic logic [15:0] max3(input logic [2:0][15:0] v);
    logic [15:0] m;
    m = (v[0] > v[1]) ? v[0] : v[1];
    max3 = (v[2] > m) ? v[2] : m;
  endfunction

  function automatic logic [16:0] clamp_dly(input logic [31:0] d);
    if (d < 32'(SYM_DELAY_MIN))
      clamp_dly = SYM_DELAY_MIN;
    else if (d > 32'(SYM_DELAY_MAX))
      clamp_dly = SYM_DELAY_MAX;
    else
      clamp_dly = d[16:0];
  endfunction

  // ************************************************************
  // Tick divider and evaluation enable
  // ************************************************************
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic en;
  assign en = meas_valid & ~pickup;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end
    else if (tick_cnt_r >= 32'(TICK_LEN - 1))
    begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  logic earthed_r;
  logic [1:0][31:0] bal_r;
  logic [1:0][16:0] dly_r;
  logic [31:0] ffm_asym_r;
  logic [31:0] ffm_3ph_r;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] wmask;
  logic [31:0] status;
  logic wr_go;

  assign wr_go = aw_got_r & w_got_r & ~bvalid;
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wmask[8*b +: 8] = {8{wstrb_r[b]}};
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
        wready <= 1'b0;
      end
      if (wr_go)
      begin
        bvalid <= 1'b1;
        bresp <= (awaddr_r[1:0] == 2'h0 && awaddr_r < STATUS_OFS) ? RESP_OKAY : RESP_SLVERR;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      earthed_r <= CTRL_RST[0];
      bal_r <= {U_BAL_RST, I_BAL_RST};
      dly_r <= {SYM_DELAY_MIN, SYM_DELAY_MIN};
      ffm_asym_r <= FFM_ASYM_RST;
      ffm_3ph_r <= FFM_3PH_RST;
    end
    else if (wr_go)
    begin
      case (awaddr_r)
        CTRL_OFS: if (wstrb_r[0]) earthed_r <= wdata_r[0];
        I_BAL_OFS: bal_r[0] <= (bal_r[0] & ~wmask) | (wdata_r & wmask);
        U_BAL_OFS: bal_r[1] <= (bal_r[1] & ~wmask) | (wdata_r & wmask);
        I_DLY_OFS: dly_r[0] <= clamp_dly(wdata_r);
        U_DLY_OFS: dly_r[1] <= clamp_dly(wdata_r);
        FFM_ASYM_OFS: ffm_asym_r <= (ffm_asym_r & ~wmask) | (wdata_r & wmask);
        FFM_3PH_OFS: ffm_3ph_r <= (ffm_3ph_r & ~wmask) | (wdata_r & wmask);
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (araddr)
        CTRL_OFS: rdata <= {31'h00000000, earthed_r};
        I_BAL_OFS: rdata <= bal_r[0];
        U_BAL_OFS: rdata <= bal_r[1];
        I_DLY_OFS: rdata <= {15'h0000, dly_r[0]};
        U_DLY_OFS: rdata <= {15'h0000, dly_r[1]};
        FFM_ASYM_OFS: rdata <= ffm_asym_r;
        FFM_3PH_OFS: rdata <= ffm_3ph_r;
        STATUS_OFS: rdata <= status;
        default:
        begin
          rdata <= 32'h00000000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ************************************************************
  // Current and voltage symmetry
  // ************************************************************
  logic [1:0] asym_r;
  logic [1:0] alarm_r;
  logic [1:0][16:0] sym_cnt_r;
  logic [1:0] sym_drop;

  for (genvar k = 0; k < 2; k++)
  begin : g_sym
    logic [2:0][15:0] mags;
    logic [15:0] mn;
    logic [15:0] mx;
    logic [31:0] lhs;
    logic [31:0] rhs;
    logic pick;
    assign mags = (k == 0) ? meas.i_mag : meas.u_pp;
    assign mn = min3(mags);
    assign mx = max3(mags);
    assign lhs = {8'h00, mn, 8'h00};
    assign rhs = 32'(bal_r[k][7:0]) * 32'(mx);
    assign pick = (mx > bal_r[k][31:16]) && (lhs < rhs);
    assign sym_drop[k] = (mx <= bal_r[k][31:16]) ||
                         (lhs * 32'(DROP_DEN) >= rhs * 32'(DROP_NUM));

    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        asym_r[k] <= 1'b0;
        sym_cnt_r[k] <= 17'h00000;
        alarm_r[k] <= 1'b0;
      end
      else if (en)
      begin
        if (pick)
          asym_r[k] <= 1'b1;
        else if (sym_drop[k])
          asym_r[k] <= 1'b0;
        if (!asym_r[k])
          sym_cnt_r[k] <= 17'h00000;
        else if (tick_r && sym_cnt_r[k] < dly_r[k])
          sym_cnt_r[k] <= sym_cnt_r[k] + 17'h00001;
        alarm_r[k] <= asym_r[k] && (sym_cnt_r[k] >= dly_r[k]);
      end
    end
  end

  // ************************************************************
  // Broken wire monitoring
  // ************************************************************
  logic [2:0][15:0] prev_i_r;
  logic [2:0] susp_r;
  logic [2:0] local_nxt;
  logic [2:0] remote_nxt;
  logic multi;

  for (genvar j = 0; j < 3; j++)
  begin : g_bw
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        prev_i_r[j] <= 16'h0000;
        susp_r[j] <= 1'b0;
      end
      else
      begin
        if (en)
          prev_i_r[j] <= meas.i_mag[j];
        if (peer.remote_high_fault || (en && meas.i_mag[j] > NOISE_I))
          susp_r[j] <= 1'b0;
        else if (en && peer.comm_ok && !peer.remote_stable)
          susp_r[j] <= 1'b0;
        else if (en && prev_i_r[j] > BW_LOAD_MIN && meas.i_mag[j] <= NOISE_I)
          susp_r[j] <= 1'b1;
      end
    end
  end

  assign multi = (susp_r[0] & susp_r[1]) | (susp_r[0] & susp_r[2]) | (susp_r[1] & susp_r[2]);
  assign local_nxt = susp_r & {3{peer.comm_ok | ~multi}};
  assign remote_nxt = peer.remote_break & {3{peer.comm_ok & ~peer.remote_high_fault}};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      local_open_ct_phase_alarm <= 3'h0;
      remote_open_ct_phase_alarm <= 3'h0;
      break_tx <= 3'h0;
      diff_block <= 1'b0;
    end
    else
    begin
      local_open_ct_phase_alarm <= local_nxt;
      remote_open_ct_phase_alarm <= remote_nxt;
      break_tx <= susp_r & {3{peer.comm_ok}};
      diff_block <= ~peer.comm_ok | (|local_nxt) | (|remote_nxt);
    end
  end

  // ************************************************************
  // Phase rotation
  // ************************************************************
  logic all_hi;
  assign all_hi = (meas.u_pe[0] > ROT_MIN_U) && (meas.u_pe[1] > ROT_MIN_U) &&
                  (meas.u_pe[2] > ROT_MIN_U);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_rotation_alarm <= 1'b0;
    else if (en && all_hi)
      phase_rotation_alarm <= meas.rot_negative;
  end

  // ************************************************************
  // Asymmetrical fuse failure
  // ************************************************************
  mcs_ffm_t ffm_r;
  logic [16:0] ffm_cnt_r;
  logic volt_crit;
  logic cur_sym;
  logic i_flow;
  logic ffm_blk;
  logic hold_done;

  assign volt_crit = (meas.u2 > ffm_asym_r[15:0]) ||
                     (earthed_r && meas.u0 > ffm_asym_r[15:0]);
  assign cur_sym = (meas.i0 < ffm_asym_r[31:16]) && (meas.i2 < ffm_asym_r[31:16]);
  assign i_flow = (meas.i_mag[0] > NOISE_I) || (meas.i_mag[1] > NOISE_I) ||
                  (meas.i_mag[2] > NOISE_I);
  assign hold_done = ffm_cnt_r >= FFM_HOLD_TICKS;
  assign ffm_blk = (ffm_r == FFM_BLOCK) || (ffm_r == FFM_LATCHED) || (ffm_r == FFM_RELEASE);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ffm_r <= FFM_IDLE;
      ffm_cnt_r <= 17'h00000;
    end
    else if (en)
    begin
      if (tick_r && !hold_done)
        ffm_cnt_r <= ffm_cnt_r + 17'h00001;
      case (ffm_r)
        FFM_IDLE:
          if (volt_crit && cur_sym && i_flow && !single_pole_open)
          begin
            ffm_r <= FFM_BLOCK;
            ffm_cnt_r <= 17'h00000;
          end
        FFM_BLOCK:
          if (!volt_crit)
            ffm_r <= FFM_IDLE;
          else if (!cur_sym && !hold_done)
            ffm_r <= FFM_LIFTED;
          else if (hold_done)
            ffm_r <= FFM_LATCHED;
        FFM_LIFTED:
          if (!volt_crit)
            ffm_r <= FFM_IDLE;
          else if (cur_sym)
            ffm_r <= FFM_BLOCK;
        FFM_LATCHED:
          if (!volt_crit)
          begin
            ffm_r <= FFM_RELEASE;
            ffm_cnt_r <= 17'h00000;
          end
        FFM_RELEASE:
          if (volt_crit)
            ffm_r <= FFM_LATCHED;
          else if (hold_done)
            ffm_r <= FFM_IDLE;
        default: ffm_r <= FFM_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Three-phase voltage failure
  // ************************************************************
  logic [2:0] u_low;
  logic [2:0] i_cond;
  logic three_nxt;
  logic three_r;

  for (genvar p = 0; p < 3; p++)
  begin : g_3ph
    logic [15:0] di;
    assign di = (meas.i_mag[p] > meas.i_stored[p]) ? meas.i_mag[p] - meas.i_stored[p] :
                meas.i_stored[p] - meas.i_mag[p];
    assign u_low[p] = meas.u_pe[p] < ffm_3ph_r[15:0];
    assign i_cond[p] = meas.stored_valid ? (di < ffm_3ph_r[31:16]) :
                       (meas.i_mag[p] > NOISE_I);
  end

  assign three_nxt = (&u_low) & (&i_cond);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      three_r <= 1'b0;
    else if (en)
      three_r <= three_nxt;
  end

  // ************************************************************
  // Alarm outputs and status
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      current_asym_alarm <= 1'b0;
      voltage_asym_alarm <= 1'b0;
      vt_circuit_loss_alarm <= 1'b0;
      undervoltage_block <= 1'b0;
    end
    else
    begin
      current_asym_alarm <= alarm_r[0];
      voltage_asym_alarm <= alarm_r[1];
      vt_circuit_loss_alarm <= ffm_blk | three_r;
      undervoltage_block <= ffm_blk | three_r;
    end
  end

  assign status = {14'h0000, ffm_r, three_r, diff_block, remote_open_ct_phase_alarm,
                   local_open_ct_phase_alarm, phase_rotation_alarm, asym_r, alarm_r};

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_pickup_freeze: assert property (pickup |=> $stable(asym_r) && $stable(ffm_r))
    else $error("state moved during pickup");
  a_cur_hyst: assert property (en && asym_r[0] && !sym_drop[0] |=> asym_r[0])
    else $error("current asymmetry dropped inside hysteresis");
  a_i_delay_met: assert property ($rose(alarm_r[0]) |-> sym_cnt_r[0] >= dly_r[0])
    else $error("current alarm before delay");
  a_cnt_clear: assert property (en && !asym_r[1] |=> sym_cnt_r[1] == 17'h00000)
    else $error("voltage delay counter not cleared");
  a_bw_emerg: assert property (!peer.comm_ok && multi |=> local_open_ct_phase_alarm == 3'h0)
    else $error("multipole break shown in emergency");
  a_bw_block: assert property (|local_open_ct_phase_alarm |-> diff_block)
    else $error("break alarm without differential block");
  a_bw_cancel: assert property (peer.remote_high_fault |=> susp_r == 3'h0)
    else $error("suspicion kept on remote high fault");
  a_ffm_spo: assert property (ffm_r == FFM_IDLE && single_pole_open |=> ffm_r == FFM_IDLE)
    else $error("immediate block during single-pole open");
  a_ffm_latch: assert property (en && ffm_r == FFM_BLOCK && volt_crit && hold_done
    |=> ffm_r == FFM_LATCHED)
    else $error("fuse failure did not latch");
  a_3ph_block: assert property (three_r |=> undervoltage_block ##0 vt_circuit_loss_alarm)
    else $error("three-phase failure not blocking");
  a_rot_alarm: assert property (en && all_hi && meas.rot_negative |=> phase_rotation_alarm)
    else $error("negative rotation not flagged");

  c_i_alarm: cover property ($rose(current_asym_alarm));
  c_ffm_latched: cover property (ffm_r == FFM_LATCHED ##1 ffm_r == FFM_RELEASE);
  c_three_phase: cover property ($rose(three_r));
  c_local_break: cover property ($rose(|local_open_ct_phase_alarm));

endmodule

/* testbench/mcs_front_model.sv */
`timescale 1ns/1ns
module mcs_front_model (
  input wire logic core_clk,
  input wire logic [2:0] break_rx,
  output mcs_pkg::mcs_meas_t meas,
  output mcs_pkg::mcs_peer_t peer,
  output logic [2:0] peer_alarm
);
  import mcs_pkg::*;
  typedef logic [15:0] mcs_w_t;

  // ************************************************************
  // Peer ends
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    peer_alarm <= break_rx;
  end

  initial
  begin
    meas = '0;
    meas.i_mag = {3{16'h03E8}};
    meas.u_pe = {3{16'h168E}};
    meas.u_pp = {3{16'h2710}};
    peer = 6'h28;
  end

  task automatic set_i(input mcs_w_t a, input mcs_w_t b, input mcs_w_t c);
    meas.i_mag <= {c, b, a};
  endtask
  task automatic set_upe(input mcs_w_t a, input mcs_w_t b, input mcs_w_t c);
    meas.u_pe <= {c, b, a};
  endtask
  task automatic set_upp(input mcs_w_t a, input mcs_w_t b, input mcs_w_t c);
    meas.u_pp <= {c, b, a};
  endtask
  task automatic set_seq(input mcs_w_t u0, input mcs_w_t u2, input mcs_w_t i0);
    meas.u0 <= u0;
    meas.u2 <= u2;
    meas.i0 <= i0;
  endtask
  task automatic set_store(input logic v, input mcs_w_t a);
    meas.stored_valid <= v;
    meas.i_stored <= {3{a}};
  endtask
  task automatic set_rot(input logic r);
    meas.rot_negative <= r;
  endtask
  task automatic set_peer(input logic c, input logic h, input logic [2:0] rb);
    peer <= {c, h, 1'b1, rb};
  endtask
endmodule

/* testbench/mcs_top_test.sv */
`timescale 1ns/1ns
module mcs_top_test;
  import mcs_pkg::*;
  localparam logic [15:0] IN = 16'h03E8;
  localparam logic [15:0] UPE = 16'h168E;
  localparam logic [15:0] UPP = 16'h2710;
  logic core_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, meas_valid, pickup, single_pole_open;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  mcs_meas_t meas;
  mcs_peer_t peer;
  logic current_asym_alarm, voltage_asym_alarm, diff_block, phase_rotation_alarm;
  logic vt_circuit_loss_alarm, undervoltage_block;
  logic [2:0] local_open_ct_phase_alarm, remote_open_ct_phase_alarm, break_tx, peer_alarm;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] ra [7] = '{CTRL_OFS, I_BAL_OFS, U_BAL_OFS, I_DLY_OFS, U_DLY_OFS,
    FFM_ASYM_OFS, FFM_3PH_OFS};
  logic [31:0] rv [7] = '{CTRL_RST, I_BAL_RST, U_BAL_RST, 32'h00001388, 32'h00001388,
    FFM_ASYM_RST, FFM_3PH_RST};

  mcs_top #(.TICK_LEN(4)) dut (.core_clk, .rst_n, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .meas, .meas_valid, .pickup, .single_pole_open,
    .peer, .current_asym_alarm, .voltage_asym_alarm, .local_open_ct_phase_alarm,
    .remote_open_ct_phase_alarm, .break_tx, .diff_block, .phase_rotation_alarm,
    .vt_circuit_loss_alarm, .undervoltage_block);
  mcs_front_model fe (.core_clk, .break_rx(break_tx), .meas, .peer, .peer_alarm);

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (arready && arvalid) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd_data = rdata;
    check(rresp, er);
  endtask
  task automatic st(input int b, input logic e);
    rd(STATUS_OFS, RESP_OKAY);
    check(rd_data[b], e);
  endtask
  task automatic ub(input logic e);
    cyc(6);
    check(undervoltage_block, e);
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // Sequence
  // ************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    #(50 * 60000);
    bad_count++;
    test_done();
  end
  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, pickup, single_pole_open} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    meas_valid = 1'b1;
    cyc(3);
    rst_n <= 1'b1;
    for (int k = 0; k < 7; k++)
    begin
      rd(ra[k], RESP_OKAY);
      check(rd_data, rv[k]);
    end
    rd(8'h40, RESP_SLVERR);
    wr(STATUS_OFS, 32'h00000000, RESP_SLVERR);
    wr(I_DLY_OFS, 32'h7FFFFFFF, RESP_OKAY);
    rd(I_DLY_OFS, RESP_OKAY);
    check(rd_data, 32'h000186A0);
    wr(I_DLY_OFS, 32'h00000001, RESP_OKAY);
    rd(I_DLY_OFS, RESP_OKAY);
    check(rd_data, 32'h00001388);
    $display("test registers done");
    fe.set_rot(1'b1);
    cyc(6);
    check(phase_rotation_alarm, 1'b1);
    fe.set_rot(1'b0);
    fe.set_upe(16'h07D0, UPE, UPE);
    cyc(6);
    check(phase_rotation_alarm, 1'b1);
    fe.set_upe(UPE, UPE, UPE);
    cyc(6);
    check(phase_rotation_alarm, 1'b0);
    $display("test rotation done");
    check(diff_block, 1'b0);
    fe.set_i(16'h0000, IN, IN);
    cyc(6);
    check(local_open_ct_phase_alarm, 3'h1);
    check(break_tx, 3'h1);
    check(diff_block, 1'b1);
    check(peer_alarm, 3'h1);
    fe.set_i(IN, IN, IN);
    cyc(6);
    check({local_open_ct_phase_alarm, diff_block}, 4'h0);
    fe.set_i(16'h0000, IN, IN);
    cyc(6);
    fe.set_peer(1'b1, 1'b1, 3'h0);
    cyc(6);
    check(local_open_ct_phase_alarm, 3'h0);
    fe.set_peer(1'b1, 1'b0, 3'h2);
    fe.set_i(IN, IN, IN);
    cyc(6);
    check({remote_open_ct_phase_alarm, diff_block}, 4'h5);
    fe.set_peer(1'b0, 1'b0, 3'h0);
    fe.set_i(16'h0000, IN, IN);
    cyc(6);
    check({local_open_ct_phase_alarm, break_tx, diff_block}, 7'h11);
    fe.set_i(IN, IN, IN);
    cyc(6);
    fe.set_i(16'h0000, 16'h0000, IN);
    cyc(6);
    check(local_open_ct_phase_alarm, 3'h0);
    fe.set_i(IN, IN, IN);
    fe.set_peer(1'b1, 1'b0, 3'h0);
    cyc(6);
    $display("test broken wire done");
    fe.set_upe(16'h01F4, 16'h01F4, 16'h01F4);
    ub(1'b1);
    fe.set_i(16'h001E, 16'h001E, 16'h001E);
    ub(1'b0);
    fe.set_i(IN, IN, IN);
    fe.set_store(1'b1, IN);
    ub(1'b1);
    fe.set_store(1'b1, 16'h01F4);
    ub(1'b0);
    fe.set_store(1'b1, IN);
    ub(1'b1);
    fe.set_upe(UPE, UPE, UPE);
    ub(1'b0);
    $display("test three phase done");
    pickup <= 1'b1;
    fe.set_i(IN, IN, 16'h0190);
    cyc(6);
    st(2, 1'b0);
    pickup <= 1'b0;
    cyc(6);
    st(2, 1'b1);
    cyc(19850);
    check(current_asym_alarm, 1'b0);
    cyc(300);
    check(current_asym_alarm, 1'b1);
    fe.set_i(IN, IN, 16'h01F9);
    cyc(6);
    st(2, 1'b1);
    fe.set_i(IN, IN, 16'h0258);
    cyc(6);
    st(2, 1'b0);
    check(current_asym_alarm, 1'b0);
    fe.set_upp(UPP, UPP, 16'h0BB8);
    cyc(6);
    st(3, 1'b1);
    check(voltage_asym_alarm, 1'b0);
    fe.set_upp(UPP, UPP, UPP);
    cyc(6);
    st(3, 1'b0);
    $display("test symmetry done");
    single_pole_open <= 1'b1;
    fe.set_seq(16'h0000, 16'h0BB8, 16'h0000);
    ub(1'b0);
    fe.set_seq(16'h0000, 16'h0000, 16'h0000);
    single_pole_open <= 1'b0;
    wr(CTRL_OFS, 32'h00000000, RESP_OKAY);
    fe.set_seq(16'h0BB8, 16'h0000, 16'h0000);
    ub(1'b0);
    wr(CTRL_OFS, 32'h00000001, RESP_OKAY);
    ub(1'b1);
    check(vt_circuit_loss_alarm, 1'b1);
    fe.set_seq(16'h0BB8, 16'h0000, 16'h01F4);
    ub(1'b0);
    $display("test fuse failure done");
    test_done();
  end
endmodule
